// [verilog/rsf_pkg.sv]
package rsf_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_STATUS0  = 4'h0;
  localparam logic [3:0] ADDR_STATUS1  = 4'h4;
  localparam logic [3:0] ADDR_CONTROL  = 4'h8;
  localparam logic [3:0] ADDR_LEVEL    = 4'hC;
  // status 0 fields
  localparam int ST0_DIS1  = 0;
  localparam int ST0_DIS2  = 1;
  localparam int ST0_OCP1  = 2;
  localparam int ST0_OCP2  = 3;
  localparam int ST0_PNG1  = 4;
  localparam int ST0_PNG2  = 5;
  localparam int ST0_UV    = 6;
  localparam int ST0_OT    = 7;
  // status 1 fields
  localparam int ST1_CP1   = 0;
  localparam int ST1_CP2   = 1;
  localparam int ST1_TD1   = 2;
  localparam int ST1_TD2   = 3;
  localparam int ST1_EPF   = 4;
  localparam int ST1_BH1   = 6;
  localparam int ST1_BH2   = 7;
  // control fields
  localparam int CTL_EN1   = 0;
  localparam int CTL_EN2   = 1;
  localparam int CTL_RSM   = 2;
  localparam int CTL_TC1   = 3;
  localparam int CTL_TC2   = 4;
  localparam int CTL_PFD0  = 5;
  localparam int CTL_PFD1  = 6;
  localparam int LVL_CH1   = 0;
  localparam int LVL_CH2   = 4;
  // reset values
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  localparam logic [7:0] LEVEL_RESET   = 8'h22;
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int EPF_D1_US      = 11500;
  localparam int EPF_D2_US      = 46000;
  localparam int EPF_D3_US      = 92000;
  localparam int RETRY_US       = 1000000;
  localparam int EPF_D1_CYC     = EPF_D1_US * CLK_MHZ;
  localparam int EPF_D2_CYC     = EPF_D2_US * CLK_MHZ;
  localparam int EPF_D3_CYC     = EPF_D3_US * CLK_MHZ;
  localparam int RETRY_CYC      = RETRY_US * CLK_MHZ;
  // level targets in millivolts
  localparam logic [14:0] MV_NONE  = 15'h0000;
  typedef enum logic [1:0] {
    RSF_IDLE = 2'b00,
    RSF_RESP = 2'b01
  } rsf_bus_e;
endpackage

// [verilog/rsf_status.sv]
// Operation
// [RQ1] decode each 4-bit level code to one of eight levels, 13.333 to 19.667 V
// [RQ2] delay select: 00 none, 01 11.5 ms, 10 46 ms, 11 92 ms
// [RQ3] power fail, undervoltage, overcurrent, overtemp each set own status bit
// [RQ4] latched fault holds until completed status read with fault gone
// [RQ5] overcurrent and overtemp latch only with restart mode 0, else auto retry
// [RQ6] undervoltage sets flag, disables both outputs, pulls interrupt low
// [RQ7] undervoltage flag clears only through a completed status read
// [RQ8] disabled flag set by any fault or cleared output enable
// [RQ9] disabled flag clears only with no fault and output re-enabled
// [RQ10] power-not-good, charge-pump-ok, tone-detect follow inputs live
// [RQ11] boost-high follows comparator hysteresis, never touches interrupt
// [RQ12] host reacts to interrupt or polls, re-reading status until change
// [RQ13] low charge pump clears ok flag, disables output, sets disabled flag
// [RQ14] overcurrent flag set only after limit exceeded past disable time
// [RQ15] power-not-good from window comparator while channel enabled
// [RQ16] tone detect uses transmit threshold at control 1, receive at 0
// [RQ17] overtemp sets its flag and both disabled flags
// [RQ18] power fail below threshold sets flag and pulls interrupt low
// [RQ19] power fail flag clears only after selected delay past recovery
// [RQ20] lowest code bit is lsb, highest is msb
// [RQ21] auto retry resets overcurrent every 1 s, re-enables if fault gone
// [RQ22] interrupt low while any interrupt flag set, released after clearing read
// [RQ23] undefined level codes keep output disabled
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
module rsf_status #(
  parameter int EPF_D1_CYCLES = rsf_pkg::EPF_D1_CYC,
  parameter int EPF_D2_CYCLES = rsf_pkg::EPF_D2_CYC,
  parameter int EPF_D3_CYCLES = rsf_pkg::EPF_D3_CYC,
  parameter int RETRY_CYCLES  = rsf_pkg::RETRY_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        uv_in,
  input  wire logic        oc_over_limit1,
  input  wire logic        oc_over_limit2,
  input  wire logic        ot_in,
  input  wire logic        cp_low1,
  input  wire logic        cp_low2,
  input  wire logic        out_low_9pct1,
  input  wire logic        out_in_5pct1,
  input  wire logic        out_low_9pct2,
  input  wire logic        out_in_5pct2,
  input  wire logic        tone_xmt_ok1,
  input  wire logic        tone_rcv_ok1,
  input  wire logic        tone_xmt_ok2,
  input  wire logic        tone_rcv_ok2,
  input  wire logic        boost_above_hi1,
  input  wire logic        boost_below_lo1,
  input  wire logic        boost_above_hi2,
  input  wire logic        boost_below_lo2,
  input  wire logic        pf_below_th,
  input  wire logic        pf_above_hys,
  output logic             channel_output_enable1,
  output logic             channel_output_enable2,
  output logic [14:0]      level_mv1,
  output logic [14:0]      level_mv2,
  output logic             irq_n
);

  ////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic [14:0] level_decode(input logic [3:0] code);
    logic [14:0] mv;
    mv = rsf_pkg::MV_NONE;
    case (code) // [RQ1] [RQ20]
      4'h2:    mv = 15'h3415;
      4'h3:    mv = 15'h3563;
      4'h5:    mv = 15'h37FD;
      4'h7:    mv = 15'h3D33;
      4'hB:    mv = 15'h48EB;
      4'hC:    mv = 15'h4A38;
      4'hD:    mv = 15'h4B85;
      4'hE:    mv = 15'h4CD3;
      default: mv = rsf_pkg::MV_NONE; // [RQ23]
    endcase
    return mv;
  endfunction

  function automatic logic [26:0] pf_delay(input logic [1:0] sel);
    logic [26:0] d;
    d = 27'h0000000;
    case (sel) // [RQ2]
      2'b00:   d = 27'h0000000;
      2'b01:   d = 27'(EPF_D1_CYCLES);
      2'b10:   d = 27'(EPF_D2_CYCLES);
      default: d = 27'(EPF_D3_CYCLES);
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, change counts when 2nd and 3rd agree
  localparam int NIN = 20;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] sync3;
  logic [NIN-1:0] clean;
  assign raw_in = {uv_in, oc_over_limit1, oc_over_limit2, ot_in, cp_low1, cp_low2,
                   out_low_9pct1, out_in_5pct1, out_low_9pct2, out_in_5pct2,
                   tone_xmt_ok1, tone_rcv_ok1, tone_xmt_ok2, tone_rcv_ok2,
                   boost_above_hi1, boost_below_lo1, boost_above_hi2, boost_below_lo2,
                   pf_below_th, pf_above_hys};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      clean <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      clean <= (sync2 & sync3) | (clean & (sync2 | sync3));
    end
  end
  logic s_uv, s_oc1, s_oc2, s_ot, s_cp1, s_cp2, s_lo1, s_in1, s_lo2, s_in2;
  logic s_tx1, s_rx1, s_tx2, s_rx2, s_bh1, s_bl1, s_bh2, s_bl2, s_pfb, s_pfa;
  assign {s_uv, s_oc1, s_oc2, s_ot, s_cp1, s_cp2, s_lo1, s_in1, s_lo2, s_in2,
          s_tx1, s_rx1, s_tx2, s_rx2, s_bh1, s_bl1, s_bh2, s_bl2, s_pfb, s_pfa} = clean;

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic [6:0] control;
  logic [7:0] level_code;
  logic       wr_fire;
  logic       rd_fire;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic       aw_held;
  logic       w_held;
  logic       s_axi_wstrb_q;
  logic       restart_mode_select;
  logic       tone_control1;
  logic       tone_control2;
  assign restart_mode_select = control[rsf_pkg::CTL_RSM];
  assign tone_control1       = control[rsf_pkg::CTL_TC1];
  assign tone_control2       = control[rsf_pkg::CTL_TC2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control    <= rsf_pkg::CONTROL_RESET;
      level_code <= rsf_pkg::LEVEL_RESET;
    end else if (wr_fire) begin
      if (aw_addr == rsf_pkg::ADDR_CONTROL && s_axi_wstrb_q) begin
        control <= w_data[6:0];
      end
      if (aw_addr == rsf_pkg::ADDR_LEVEL && s_axi_wstrb_q) begin
        level_code <= w_data[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      s_axi_wstrb_q <= 1'b0;
      s_axi_bvalid  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held        <= 1'b1;
        w_data        <= s_axi_wdata;
        s_axi_wstrb_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read path; a read of either status register clears latches
  rsf_pkg::rsf_bus_e rd_state;
  logic [7:0] status0;
  logic [7:0] status1;
  logic       status_read_done;
  logic       rd_is_status;
  assign s_axi_arready = (rd_state == rsf_pkg::RSF_IDLE);
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_rresp   = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state     <= rsf_pkg::RSF_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      case (rd_state)
        rsf_pkg::RSF_IDLE: begin
          if (rd_fire) begin
            rd_state     <= rsf_pkg::RSF_RESP;
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
              rsf_pkg::ADDR_STATUS0: s_axi_rdata <= {24'h000000, status0};
              rsf_pkg::ADDR_STATUS1: s_axi_rdata <= {24'h000000, status1};
              rsf_pkg::ADDR_CONTROL: s_axi_rdata <= {25'h0000000, control};
              rsf_pkg::ADDR_LEVEL:   s_axi_rdata <= {24'h000000, level_code};
              default:               s_axi_rdata <= 32'h00000000;
            endcase
          end
        end
        rsf_pkg::RSF_RESP: begin
          if (s_axi_rready) begin
            rd_state     <= rsf_pkg::RSF_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: rd_state <= rsf_pkg::RSF_IDLE;
      endcase
    end
  end
  // clear only when the host has really taken the data
  assign status_read_done = (rd_state == rsf_pkg::RSF_RESP) && s_axi_rready && rd_is_status;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_is_status <= 1'b0;
    end else if (rd_fire) begin
      rd_is_status <= (s_axi_araddr == rsf_pkg::ADDR_STATUS0) || (s_axi_araddr == rsf_pkg::ADDR_STATUS1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latched faults: set wins over read clear
  logic undervoltage_flag;
  logic overcurrent_flag1;
  logic overcurrent_flag2;
  logic overtemp_flag;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      undervoltage_flag <= 1'b0;
    end else if (s_uv) begin
      undervoltage_flag <= 1'b1; // [RQ3] [RQ6]
    end else if (status_read_done) begin
      undervoltage_flag <= 1'b0; // [RQ4] [RQ7]
    end
  end

  // overcurrent must persist for the disable time; timer lives outside
  logic [31:0] retry_cnt;
  logic        retry_tick;
  assign retry_tick = (retry_cnt == 32'(RETRY_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retry_cnt <= 32'h00000000;
    end else if (retry_tick) begin
      retry_cnt <= 32'h00000000;
    end else begin
      retry_cnt <= retry_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_flag1 <= 1'b0;
      overcurrent_flag2 <= 1'b0;
      overtemp_flag     <= 1'b0;
    end else begin
      // [RQ14] set input asserted only past the disable time
      if (s_oc1) begin
        overcurrent_flag1 <= 1'b1; // [RQ3]
      end else if (restart_mode_select ? retry_tick : status_read_done) begin
        overcurrent_flag1 <= 1'b0; // [RQ5] [RQ21]
      end
      if (s_oc2) begin
        overcurrent_flag2 <= 1'b1; // [RQ3]
      end else if (restart_mode_select ? retry_tick : status_read_done) begin
        overcurrent_flag2 <= 1'b0; // [RQ5] [RQ21]
      end
      if (s_ot) begin
        overtemp_flag <= 1'b1; // [RQ3] [RQ17]
      end else if (restart_mode_select ? retry_tick : status_read_done) begin
        overtemp_flag <= 1'b0; // [RQ4] [RQ5]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live flags
  logic power_not_good_flag1, power_not_good_flag2;
  logic boost_high_flag1, boost_high_flag2;
  logic charge_pump_ok_flag1, charge_pump_ok_flag2;
  logic tone_detect_flag1, tone_detect_flag2;
  assign charge_pump_ok_flag1 = !s_cp1; // [RQ10] [RQ13]
  assign charge_pump_ok_flag2 = !s_cp2; // [RQ13]
  assign tone_detect_flag1 = tone_control1 ? s_tx1 : s_rx1; // [RQ16] [RQ10]
  assign tone_detect_flag2 = tone_control2 ? s_tx2 : s_rx2; // [RQ16]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_not_good_flag1 <= 1'b0;
      power_not_good_flag2 <= 1'b0;
      boost_high_flag1     <= 1'b0;
      boost_high_flag2     <= 1'b0;
    end else begin
      if (!channel_output_enable1) begin
        power_not_good_flag1 <= 1'b0;
      end else if (s_lo1) begin
        power_not_good_flag1 <= 1'b1; // [RQ15] [RQ10]
      end else if (s_in1) begin
        power_not_good_flag1 <= 1'b0; // [RQ15]
      end
      if (!channel_output_enable2) begin
        power_not_good_flag2 <= 1'b0;
      end else if (s_lo2) begin
        power_not_good_flag2 <= 1'b1; // [RQ15]
      end else if (s_in2) begin
        power_not_good_flag2 <= 1'b0; // [RQ15]
      end
      if (s_bh1) begin
        boost_high_flag1 <= 1'b1; // [RQ11]
      end else if (s_bl1) begin
        boost_high_flag1 <= 1'b0; // [RQ11]
      end
      if (s_bh2) begin
        boost_high_flag2 <= 1'b1; // [RQ11]
      end else if (s_bl2) begin
        boost_high_flag2 <= 1'b0; // [RQ11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // early power fail with release delay
  logic        early_power_fail_flag;
  logic [26:0] pf_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_power_fail_flag <= 1'b0;
      pf_cnt                <= 27'h0000000;
    end else if (s_pfb) begin
      early_power_fail_flag <= 1'b1; // [RQ18] [RQ3]
      pf_cnt                <= 27'h0000000;
    end else if (early_power_fail_flag && s_pfa) begin
      if (pf_cnt >= pf_delay({control[rsf_pkg::CTL_PFD1], control[rsf_pkg::CTL_PFD0]})) begin
        early_power_fail_flag <= 1'b0; // [RQ19]
      end else begin
        pf_cnt <= pf_cnt + 27'h0000001;
      end
    end else begin
      pf_cnt <= 27'h0000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // disabled flags and outputs
  logic channel_disabled_flag1, channel_disabled_flag2;
  logic any_fault1, any_fault2;
  assign level_mv1 = level_decode(level_code[rsf_pkg::LVL_CH1 +: 4]);
  assign level_mv2 = level_decode(level_code[rsf_pkg::LVL_CH2 +: 4]);
  // undefined code counts as a fault so the output stays off
  assign any_fault1 = undervoltage_flag || overcurrent_flag1 || overtemp_flag || !charge_pump_ok_flag1
                      || (level_mv1 == rsf_pkg::MV_NONE); // [RQ23]
  assign any_fault2 = undervoltage_flag || overcurrent_flag2 || overtemp_flag || !charge_pump_ok_flag2
                      || (level_mv2 == rsf_pkg::MV_NONE); // [RQ23]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_disabled_flag1 <= 1'b1;
      channel_disabled_flag2 <= 1'b1;
    end else begin
      if (any_fault1 || !control[rsf_pkg::CTL_EN1]) begin
        channel_disabled_flag1 <= 1'b1; // [RQ8] [RQ6] [RQ17]
      end else begin
        channel_disabled_flag1 <= 1'b0; // [RQ9]
      end
      if (any_fault2 || !control[rsf_pkg::CTL_EN2]) begin
        channel_disabled_flag2 <= 1'b1; // [RQ8] [RQ13]
      end else begin
        channel_disabled_flag2 <= 1'b0; // [RQ9]
      end
    end
  end
  assign channel_output_enable1 = !channel_disabled_flag1; // [RQ6] [RQ13]
  assign channel_output_enable2 = !channel_disabled_flag2;

  // boost-high is left out of the interrupt term on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(undervoltage_flag || overcurrent_flag1 || overcurrent_flag2 || overtemp_flag
                 || early_power_fail_flag); // [RQ22] [RQ6] [RQ18] [RQ11] [RQ12]
    end
  end

  assign status0 = {overtemp_flag, undervoltage_flag, power_not_good_flag2, power_not_good_flag1,
                    overcurrent_flag2, overcurrent_flag1, channel_disabled_flag2, channel_disabled_flag1};
  assign status1 = {boost_high_flag2, boost_high_flag1, 1'b0, early_power_fail_flag,
                    tone_detect_flag2, tone_detect_flag1, charge_pump_ok_flag2, charge_pump_ok_flag1};

endmodule

// [tb/rsf_status_checker.sv]
module rsf_status_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic uv_in,
  input wire logic ot_in,
  input wire logic cp_low1,
  input wire logic oc_over_limit1,
  input wire logic pf_below_th,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic channel_output_enable1,
  input wire logic channel_output_enable2,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // ranges allow for the three-stage input synchroniser
  uv_off_a: assert property (uv_in |-> ##[1:10] !channel_output_enable1 && !channel_output_enable2)
    else $error("undervoltage left an output on");
  uv_irq_a: assert property (uv_in |-> ##[1:10] !irq_n)
    else $error("undervoltage did not pull interrupt low");
  ot_off_a: assert property (ot_in |-> ##[1:10] !channel_output_enable1 && !channel_output_enable2)
    else $error("overtemp left an output on");
  cp_off_a: assert property (cp_low1 |-> ##[1:10] !channel_output_enable1)
    else $error("low charge pump left output on");
  oc_off_a: assert property (oc_over_limit1 |-> ##[1:10] !channel_output_enable1)
    else $error("overcurrent left output on");
  pf_irq_a: assert property (pf_below_th |-> ##[1:10] !irq_n)
    else $error("power fail did not pull interrupt low");
  uv_hold_a: assert property (uv_in [*8] |-> !irq_n && !channel_output_enable2)
    else $error("interrupt or output released during undervoltage");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("status read not answered");
  uv_seen_c: cover property (uv_in ##1 !irq_n);
  pf_seen_c: cover property (pf_below_th ##1 !irq_n);
  read_seen_c: cover property (s_axi_arvalid && s_axi_arready);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rsf_status rsf_status_checker rsf_status_checker_i (.aclk, .aresetn, .uv_in, .ot_in, .cp_low1,
  .oc_over_limit1, .pf_below_th, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .channel_output_enable1,
  .channel_output_enable2, .irq_n);

// [tb/rsf_host.sv]
// host side: only one transfer of each kind at a time
module rsf_host (
  input  wire logic        aclk,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  output logic [31:0]      s_axi_wdata,
  output logic             s_axi_wvalid,
  output logic             s_axi_bready,
  output logic [3:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int timeouts = 0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) timeouts++;
  endtask
  // a status read is what releases latched faults
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
    if (n >= 50) timeouts++;
  endtask
endmodule

// [tb/test_regulator_status_flags.sv]
module test_regulator_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [5:0]  flt = '0;
  logic [9:0]  lv = '0;
  logic        pf = 1'b0;
  logic [14:0] level_mv1, level_mv2;
  logic        channel_output_enable1, channel_output_enable2, irq_n;
  logic [7:0]  d;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // short delays so every power fail delay code fits in the run
  rsf_status #(.EPF_D1_CYCLES(20), .EPF_D2_CYCLES(40), .EPF_D3_CYCLES(80), .RETRY_CYCLES(100)) rsf_status_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uv_in(flt[0]), .ot_in(flt[1]),
    .oc_over_limit1(flt[2]), .cp_low1(flt[3]), .oc_over_limit2(flt[4]), .cp_low2(flt[5]),
    .out_low_9pct1(lv[2]), .out_in_5pct1(!lv[2]), .out_low_9pct2(lv[3]), .out_in_5pct2(!lv[3]),
    .tone_xmt_ok1(lv[4]), .tone_rcv_ok1(lv[5]), .tone_xmt_ok2(lv[6]), .tone_rcv_ok2(lv[7]),
    .boost_above_hi1(lv[8]), .boost_below_lo1(!lv[8]), .boost_above_hi2(lv[9]), .boost_below_lo2(!lv[9]),
    .pf_below_th(pf), .pf_above_hys(!pf), .channel_output_enable1, .channel_output_enable2, .level_mv1,
    .level_mv2, .irq_n);
  rsf_host rsf_host_i (.aclk, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata, .s_axi_wvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] mv(input logic [3:0] c);
    case (c)
      4'h2: mv = 16'h3415;
      4'h3: mv = 16'h3563;
      4'h5: mv = 16'h37FD;
      4'h7: mv = 16'h3D33;
      4'hB: mv = 16'h48EB;
      4'hC: mv = 16'h4A38;
      4'hD: mv = 16'h4B85;
      4'hE: mv = 16'h4CD3;
      default: mv = 16'h0000;
    endcase
  endfunction
  task automatic report_and_stop;
    mismatches += rsf_host_i.timeouts;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int r, t0, n;
    int dl[4] = '{0, 20, 40, 80};
    logic [7:0] s0x[6] = '{8'h43, 8'h83, 8'h05, 8'h01, 8'h0A, 8'h02};
    logic [7:0] s1x[6] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h01};
    logic [5:0] live_only = 6'b101000;
    r = $urandom(32'hCABD);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(irq_n, 1'b1);
    chk(channel_output_enable1, 1'b0);
    rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
    chk(d, 8'h03);
    rsf_host_i.rd(rsf_pkg::ADDR_STATUS1, d);
    chk(d, 8'h03);
    rsf_host_i.rd(rsf_pkg::ADDR_LEVEL, d);
    chk(d, 8'h22);
    chk({s_axi_bresp, s_axi_rresp}, 4'h0);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      rsf_host_i.wr(rsf_pkg::ADDR_LEVEL, {~c[3:0], c[3:0]});
      repeat (2) @(posedge aclk);
      chk(level_mv1, mv(c[3:0]));
      chk(level_mv2, mv(~c[3:0]));
    end
    rsf_host_i.wr(rsf_pkg::ADDR_LEVEL, 8'h22);
    rsf_host_i.wr(rsf_pkg::ADDR_CONTROL, 8'h03);
    repeat (8) @(posedge aclk);
    rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
    chk(d, 8'h00);
    $display("test level decode done");
    // uv, ot, oc1, cp1, oc2, cp2 in turn; charge pump faults do not latch
    for (int k = 0; k < 6; k++) begin
      flt <= 6'h01 << k;
      repeat (8) @(posedge aclk);
      chk(irq_n, live_only[k]);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
      chk(d, s0x[k]);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
      chk(d, s0x[k]);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS1, d);
      chk(d, s1x[k]);
      flt <= '0;
      repeat (8) @(posedge aclk);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
      chk(d, live_only[k] ? 8'h00 : s0x[k]);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
      chk(d, 8'h00);
      chk(irq_n, 1'b1);
    end
    $display("test faults done");
    rsf_host_i.wr(rsf_pkg::ADDR_CONTROL, 8'h07);
    flt <= 6'h04;
    repeat (8) @(posedge aclk);
    rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
    chk(d, 8'h05);
    flt <= '0;
    repeat (130) @(posedge aclk);
    rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
    chk(d, 8'h00);
    chk(irq_n, 1'b1);
    $display("test auto retry done");
    for (int p = 0; p < 4; p++) begin
      rsf_host_i.wr(rsf_pkg::ADDR_CONTROL, {1'b0, p[1:0], 5'b00011});
      pf <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(irq_n, 1'b0);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS1, d);
      chk(d, 8'h13);
      pf <= 1'b0;
      t0 = cyc;
      n = 0;
      do begin
        rsf_host_i.rd(rsf_pkg::ADDR_STATUS1, d);
        n++;
      end while (d[4] && n < 60);
      chk(cyc - t0 >= dl[p] && cyc - t0 <= dl[p] + 20, 1'b1);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
      chk(irq_n, 1'b1);
    end
    $display("test power fail delay done");
    // two corners first: everything low, then everything high
    for (int i = 0; i < 24; i++) begin
      r = (i == 0) ? 0 : (i == 1) ? 32'h000003FF : $urandom;
      rsf_host_i.wr(rsf_pkg::ADDR_CONTROL, {3'b000, r[1:0], 3'b011});
      lv <= r[9:0];
      repeat (8) @(posedge aclk);
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS0, d);
      chk(d, {2'b00, r[3:2], 4'h0});
      rsf_host_i.rd(rsf_pkg::ADDR_STATUS1, d);
      chk(d, {r[9:8], 2'b00, r[1] ? r[6] : r[7], r[0] ? r[4] : r[5], 2'b11});
      chk(irq_n, 1'b1);
    end
    $display("test live flags done");
    report_and_stop();
  end
endmodule
